// *** dlp_pkg.sv ***
// Shared constants and types for the data lane pin block
package dlp_pkg;
  localparam int unsigned DQ_W = 16;
  localparam int unsigned BURST_LEN = 8;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned STROBE_PERIOD_NS = 200;
  localparam int unsigned HALF_CYC = STROBE_PERIOD_NS / (2 * CLK_NS);
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_RTT = 8'h0C;
  localparam logic [7:0] OFF_RGO = 8'h10;
  localparam logic [7:0] OFF_VREF = 8'h14;
  localparam logic [7:0] OFF_WBUF = 8'h20;
  localparam logic [7:0] OFF_RBUF = 8'h40;
  localparam logic [1:0] MODE_X4 = 2'h0;
  localparam logic [1:0] MODE_X8 = 2'h1;
  localparam logic [1:0] MODE_X16 = 2'h2;
  localparam int unsigned ST_WDONE = 0;
  localparam int unsigned ST_CRC = 1;
  localparam int unsigned ST_PAR = 2;
  localparam int unsigned ST_RDONE = 3;
  localparam int unsigned ST_W = 4;
  localparam int unsigned CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h002;
  localparam logic [2:0] RTT_RST = 3'h0;
  localparam logic [2:0] RTT_HIZ = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control word, bit 9 down to bit 0
  typedef struct packed {
    logic stacked;
    logic tdqs;
    logic crc_chk;
    logic par_chk;
    logic wdbi;
    logic rdbi;
    logic vref;
    logic wcrc;
    logic [1:0] mode;
  } dlp_ctrl_t;
  // One received data beat
  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic [1:0] dmi;
  } dlp_beat_t;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_DRIVE = 3'b010,
    RD_DONE = 3'b100
  } dlp_rd_state_t;
endpackage

// *** dlp_strobe_rx.sv ***
// Strobe synchroniser and write beat capture
`timescale 1ns/1ps
`default_nettype none
module dlp_strobe_rx (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins from the controller
  input wire logic dqs_t_i,
  input wire logic dqs_c_i,
  input wire logic [dlp_pkg::DQ_W-1:0] dq_i,
  input wire logic [1:0] dmi_i,
  // Captured beat
  output logic beat_v,
  output dlp_pkg::dlp_beat_t beat
);
  logic [1:0] t_s1_r, t_s2_r;
  logic t_prev_r;
  dlp_pkg::dlp_beat_t b_s1_r, b_s2_r;
  wire logic pair_ok = t_s2_r[0] ^ t_s2_r[1];
  wire logic edge_seen = pair_ok && (t_s2_r[0] != t_prev_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t_s1_r <= 2'b10;
      t_s2_r <= 2'b10;
      t_prev_r <= 1'b0;
      b_s1_r <= '0;
      b_s2_r <= '0;
    end else begin
      t_s1_r <= {dqs_c_i, dqs_t_i};
      t_s2_r <= t_s1_r;
      b_s1_r <= {dq_i, dmi_i};
      b_s2_r <= b_s1_r;
      if (pair_ok) begin
        t_prev_r <= t_s2_r[0];
      end
    end
  end

  // Both strobe edges take a beat; a non complementary pair is ignored
  assign beat_v = edge_seen;
  assign beat = b_s2_r;
endmodule
`default_nettype wire

// *** dlp_lane_top.sv ***
// Data lane pins: write capture, read drive, DBI, mask, CRC, alert
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dlp_lane_top #(
  parameter int unsigned HALF_CYC = dlp_pkg::HALF_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command decoder events
  input wire logic wr_start,
  input wire logic ca_par_err,
  // Data pins
  input wire logic [dlp_pkg::DQ_W-1:0] dq_i,
  output logic [dlp_pkg::DQ_W-1:0] dq_o,
  output logic [dlp_pkg::DQ_W-1:0] dq_oe_n,
  input wire logic dqs_t_i,
  input wire logic dqs_c_i,
  output logic dqs_t_o,
  output logic dqs_c_o,
  output logic [1:0] dqs_oe_n,
  input wire logic [1:0] dmi_i,
  output logic [1:0] dmi_o,
  output logic [1:0] dmi_oe_n,
  // Termination and alert
  output logic [2:0] on_die_termination_value,
  output logic [2:0] dqs_rtt,
  output logic [2:0] tdqs_rtt,
  output logic alert_n,
  output logic irq
);
  dlp_pkg::dlp_ctrl_t ctrl_r;
  logic [dlp_pkg::ST_W-1:0] stat_r, mask_r;
  logic [2:0] rtt_r;
  logic [3:0] vref_r;
  logic [15:0] wbuf [dlp_pkg::BURST_LEN];
  logic [15:0] rbuf [dlp_pkg::BURST_LEN];
  logic awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic armed_r;
  logic [3:0] wcnt_r;
  logic [7:0] crc_acc_r;
  dlp_pkg::dlp_rd_state_t rd_state_r;
  logic [2:0] rbeat_r;
  logic [7:0] half_r;
  logic beat_v;
  dlp_pkg::dlp_beat_t beat;

  function automatic logic [7:0] fold(input logic [15:0] d);
    fold = d[7:0] ^ d[15:8];
  endfunction

  function automatic logic many_zeros(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, ~b[i]};
    end
    many_zeros = n > 4'h4;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  dlp_strobe_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .dqs_t_i(dqs_t_i),
    .dqs_c_i(dqs_c_i),
    .dq_i(dq_i),
    .dmi_i(dmi_i),
    .beat_v(beat_v),
    .beat(beat)
  );

  // Lane configuration
  wire logic x4 = ctrl_r.mode == dlp_pkg::MODE_X4;
  wire logic x16 = ctrl_r.mode == dlp_pkg::MODE_X16;
  wire logic [15:0] lane_mask = x4 ? 16'h000F :
                                (x16 ? 16'hFFFF : 16'h00FF);
  wire logic tdqs_on = ctrl_r.tdqs && !x4 && !x16;
  wire logic wdbi_on = ctrl_r.wdbi && !x4;
  wire logic rdbi_on = ctrl_r.rdbi && !x4;
  wire logic dm_on = !x4 && !tdqs_on && !wdbi_on;

  // Write beat handling
  wire logic take = beat_v && armed_r;
  wire logic data_beat = take && (wcnt_r < 4'(dlp_pkg::BURST_LEN));
  wire logic crc_beat = take && ctrl_r.wcrc &&
                        (wcnt_r == 4'(dlp_pkg::BURST_LEN));
  wire logic [1:0] inv = {wdbi_on && x16 && !beat.dmi[1],
                          wdbi_on && !beat.dmi[0]};
  wire logic [15:0] wfix = (beat.dq ^ {{8{inv[1]}}, {8{inv[0]}}})
                           & lane_mask;
  wire logic [1:0] keep = {!(dm_on && x16 && !beat.dmi[1]),
                           !(dm_on && !beat.dmi[0])};
  wire logic [7:0] crc_next = crc_acc_r ^ fold(wfix);
  wire logic last_data = data_beat &&
                         (wcnt_r == 4'(dlp_pkg::BURST_LEN - 1));
  wire logic wdone_ev = (last_data && !ctrl_r.wcrc) || crc_beat;
  wire logic crc_ev = crc_beat && ctrl_r.crc_chk &&
                      (wfix[7:0] != crc_acc_r);
  wire logic par_ev = ca_par_err && ctrl_r.par_chk;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= 1'b0;
      wcnt_r <= 4'h0;
      crc_acc_r <= 8'h00;
    end else if (wr_start) begin
      armed_r <= 1'b1;
      wcnt_r <= 4'h0;
      crc_acc_r <= 8'h00;
    end else if (take) begin
      armed_r <= !wdone_ev;
      wcnt_r <= wcnt_r + 4'h1;
      crc_acc_r <= crc_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (data_beat) begin
      if (keep[0]) begin
        wbuf[wcnt_r[2:0]][7:0] <= wfix[7:0];
      end
      if (keep[1]) begin
        wbuf[wcnt_r[2:0]][15:8] <= wfix[15:8];
      end
    end
  end

  // AXI4-Lite slave
  wire logic wr_fire = s_axi_awvalid && s_axi_wvalid && !awready_r &&
                       !bvalid_r;
  wire logic rd_fire = s_axi_arvalid && !arready_r && !rvalid_r;
  wire logic wr_do = awready_r;
  wire logic [7:0] wa = s_axi_awaddr;
  wire logic [7:0] ra = s_axi_araddr;
  wire logic wa_buf = wa[7:5] == dlp_pkg::OFF_RBUF[7:5];
  wire logic wa_ok = wa_buf || wa == dlp_pkg::OFF_CTRL ||
                     wa == dlp_pkg::OFF_STAT || wa == dlp_pkg::OFF_MASK ||
                     wa == dlp_pkg::OFF_RTT || wa == dlp_pkg::OFF_RGO ||
                     wa == dlp_pkg::OFF_VREF;
  wire logic [31:0] wm = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
  wire logic [31:0] cm = merge({22'h0, ctrl_r}, s_axi_wdata, s_axi_wstrb);
  wire logic ra_wbuf = ra[7:5] == dlp_pkg::OFF_WBUF[7:5];
  wire logic ra_rbuf = ra[7:5] == dlp_pkg::OFF_RBUF[7:5];
  wire logic [31:0] rd_word =
    ra == dlp_pkg::OFF_CTRL ? {22'h0, ctrl_r} :
    ra == dlp_pkg::OFF_STAT ? {28'h0, stat_r} :
    ra == dlp_pkg::OFF_MASK ? {28'h0, mask_r} :
    ra == dlp_pkg::OFF_RTT ? {29'h0, rtt_r} :
    ra == dlp_pkg::OFF_RGO ? {29'h0, rd_state_r} :
    ra == dlp_pkg::OFF_VREF ? {28'h0, vref_r} :
    ra_wbuf ? {16'h0, wbuf[ra[4:2]]} :
    ra_rbuf ? {16'h0, rbuf[ra[4:2]]} : 32'h0000_0000;
  wire logic ra_ok = ra_wbuf || ra_rbuf || ra <= dlp_pkg::OFF_VREF;
  wire logic [dlp_pkg::ST_W-1:0] w1c =
    (wr_do && wa == dlp_pkg::OFF_STAT) ? wm[dlp_pkg::ST_W-1:0] : '0;
  wire logic [dlp_pkg::ST_W-1:0] events =
    {rd_state_r == dlp_pkg::RD_DONE, par_ev, crc_ev, wdone_ev};
  wire logic [dlp_pkg::ST_W-1:0] stat_nxt = (stat_r & ~w1c) | events;
  wire logic rd_go = wr_do && wa == dlp_pkg::OFF_RGO && wm[0] &&
                     rd_state_r == dlp_pkg::RD_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= dlp_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= dlp_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      awready_r <= wr_fire;
      arready_r <= rd_fire;
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wa_ok ? dlp_pkg::RESP_OKAY : dlp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (arready_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word;
        rresp_r <= ra_ok ? dlp_pkg::RESP_OKAY : dlp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= dlp_pkg::CTRL_RST;
      mask_r <= '0;
      rtt_r <= dlp_pkg::RTT_RST;
      vref_r <= 4'h0;
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_do && wa == dlp_pkg::OFF_CTRL) begin
        ctrl_r <= cm[dlp_pkg::CTRL_W-1:0];
      end
      if (wr_do && wa == dlp_pkg::OFF_MASK) begin
        mask_r <= wm[dlp_pkg::ST_W-1:0];
      end
      if (wr_do && wa == dlp_pkg::OFF_RTT) begin
        rtt_r <= wm[2:0];
      end
      if (wr_do && wa == dlp_pkg::OFF_VREF) begin
        vref_r <= wm[3:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_do && wa_buf) begin
      rbuf[wa[4:2]] <= wm[15:0];
    end
  end

  // Read burst drive
  wire logic [15:0] rword = rbuf[rbeat_r] & lane_mask;
  wire logic [1:0] rinv = {rdbi_on && x16 && many_zeros(rword[15:8]),
                           rdbi_on && many_zeros(rword[7:0])};
  wire logic half_end = half_r == 8'(HALF_CYC - 1);
  wire logic last_rbeat = rbeat_r == 3'(dlp_pkg::BURST_LEN - 1);
  wire logic driving = rd_state_r == dlp_pkg::RD_DRIVE;
  wire logic vref_out = ctrl_r.vref && !driving;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= dlp_pkg::RD_IDLE;
      rbeat_r <= 3'h0;
      half_r <= 8'h00;
      dqs_t_o <= 1'b0;
    end else begin
      case (rd_state_r)
        dlp_pkg::RD_IDLE: begin
          half_r <= 8'h00;
          rbeat_r <= 3'h0;
          if (rd_go) begin
            rd_state_r <= dlp_pkg::RD_DRIVE;
            dqs_t_o <= 1'b1;
          end
        end
        dlp_pkg::RD_DRIVE: begin
          half_r <= half_end ? 8'h00 : half_r + 8'h01;
          if (half_end && last_rbeat) begin
            rd_state_r <= dlp_pkg::RD_DONE;
            dqs_t_o <= 1'b0;
          end else if (half_end) begin
            rbeat_r <= rbeat_r + 3'h1;
            dqs_t_o <= ~dqs_t_o;
          end
        end
        dlp_pkg::RD_DONE: rd_state_r <= dlp_pkg::RD_IDLE;
        default: rd_state_r <= dlp_pkg::RD_IDLE;
      endcase
    end
  end

  // Registered pin outputs
  wire logic drv_nxt = (rd_state_r == dlp_pkg::RD_IDLE && rd_go) ||
                       (driving && !(half_end && last_rbeat));
  wire logic [2:0] rbeat_nxt = !driving ? 3'h0 :
                               (half_end ? rbeat_r + 3'h1 : rbeat_r);
  wire logic [15:0] rw_nxt = rbuf[rbeat_nxt] & lane_mask;
  wire logic [1:0] ri_nxt = {rdbi_on && x16 && many_zeros(rw_nxt[15:8]),
                             rdbi_on && many_zeros(rw_nxt[7:0])};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_o <= '0;
      dq_oe_n <= '1;
      dqs_c_o <= 1'b1;
      dqs_oe_n <= 2'b11;
      dmi_o <= 2'b11;
      dmi_oe_n <= 2'b11;
      on_die_termination_value <= dlp_pkg::RTT_RST;
      dqs_rtt <= dlp_pkg::RTT_RST;
      tdqs_rtt <= dlp_pkg::RTT_HIZ;
      alert_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      dqs_c_o <= !(rd_state_r == dlp_pkg::RD_IDLE ? rd_go :
                   (driving && !(half_end && last_rbeat) &&
                    (half_end ? !dqs_t_o : dqs_t_o)));
      dqs_oe_n <= {!(drv_nxt && x16), !drv_nxt};
      if (drv_nxt) begin
        dq_o <= rw_nxt ^ {{8{ri_nxt[1]}}, {8{ri_nxt[0]}}};
        dq_oe_n <= ~lane_mask;
        dmi_o <= ~ri_nxt;
        dmi_oe_n <= {!(rdbi_on && x16), !rdbi_on};
      end else if (vref_out) begin
        dq_o <= {12'h000, vref_r};
        dq_oe_n <= 16'hFFF0;
        dmi_oe_n <= 2'b11;
      end else begin
        dq_oe_n <= '1;
        dmi_oe_n <= 2'b11;
      end
      on_die_termination_value <= vref_out ? dlp_pkg::RTT_HIZ : rtt_r;
      dqs_rtt <= rtt_r;
      tdqs_rtt <= tdqs_on ? rtt_r : dlp_pkg::RTT_HIZ;
      alert_n <= !((stat_r[dlp_pkg::ST_CRC] && ctrl_r.crc_chk) ||
                   (stat_r[dlp_pkg::ST_PAR] && ctrl_r.par_chk));
      irq <= |(stat_r & mask_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = awready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_crc_bad;
    crc_beat && ctrl_r.crc_chk && (wfix[7:0] != crc_acc_r);
  endsequence
  sequence s_rd_start;
    rd_go;
  endsequence

  alert_level_a: assert property (
    ##1 alert_n == !($past(stat_r[dlp_pkg::ST_CRC] && ctrl_r.crc_chk) ||
                     $past(stat_r[dlp_pkg::ST_PAR] && ctrl_r.par_chk)))
    else $error("alert level wrong");
  crc_error_a: assert property (s_crc_bad |=> ##1 !alert_n)
    else $error("crc error not alerted");
  par_ignored_a: assert property (
    (ca_par_err && !ctrl_r.par_chk && !stat_r[dlp_pkg::ST_PAR])
    |=> !stat_r[dlp_pkg::ST_PAR])
    else $error("parity flagged while off");
  strobe_pair_a: assert property (dqs_t_o != dqs_c_o)
    else $error("strobe pair not complementary");
  read_drive_a: assert property (
    s_rd_start |=> (!dqs_oe_n[0] && dqs_t_o) [*4])
    else $error("read strobe not driven");
  edge_align_a: assert property (
    (driving && $past(driving) && $changed(dq_o)) |-> $changed(dqs_t_o))
    else $error("read data not edge aligned");
  tdqs_term_a: assert property (
    tdqs_on |=> tdqs_rtt == dqs_rtt)
    else $error("termination strobe mismatch");
  x4_no_dbi_a: assert property (
    (x4 && $past(x4)) |-> dmi_oe_n == 2'b11)
    else $error("inversion driven in x4");
  vref_lanes_a: assert property (
    (vref_out && $stable(vref_out) && !rd_go) |=>
    (dq_oe_n[3:0] == 4'h0 && on_die_termination_value == dlp_pkg::RTT_HIZ))
    else $error("reference monitor not presented");
  mask_drop_a: assert property (
    (data_beat && dm_on && !beat.dmi[0]) |=>
    wbuf[$past(wcnt_r[2:0])][7:0] == $past(wbuf[wcnt_r[2:0]][7:0]))
    else $error("masked byte not dropped");
endmodule
`default_nettype wire

// *** dlp_host_model.sv ***
// Controller side model: drives write strobes, data and mask
`timescale 1ns/1ps
`default_nettype none
module dlp_host_model (
  // Clock
  input wire logic aclk,
  // Write link pins
  output logic dqs_t,
  output logic dqs_c,
  output logic [dlp_pkg::DQ_W-1:0] dq,
  output logic [1:0] dmi
);
  logic [dlp_pkg::DQ_W-1:0] beat [9];
  logic [1:0] mask [9];
  initial begin
    dqs_t = 1'h0;
    dqs_c = 1'h1;
    dq = 16'h0000;
    dmi = 2'h3;
  end
  // One burst; strobe stands still between bursts
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      dq <= beat[i];
      dmi <= mask[i];
      repeat (2) @(posedge aclk);
      dqs_t <= ~dqs_t;
      dqs_c <= dqs_t;
      repeat (2) @(posedge aclk);
    end
    dq <= ~dq;
    dmi <= ~dmi;
  endtask
endmodule
`default_nettype wire

// *** dlp_lane_top_test.sv ***
// Self-checking bench for the data lane pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module dlp_lane_top_test;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic wr_start = 1'h0, ca_par_err = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dqs_t_i, dqs_c_i, dqs_t_o, dqs_c_o, alert_n, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, dqs_oe_n, dmi_i, dmi_o, dmi_oe_n;
  logic [31:0] s_axi_rdata, v;
  logic [15:0] dq_i, dq_o, dq_oe_n;
  logic [2:0] on_die_termination_value, dqs_rtt, tdqs_rtt;
  logic [1:0] rsp;
  logic [15:0] wexp [8];
  logic [15:0] rexp [8];
  logic [7:0] crc;
  int error_cnt = 0, checks = 0, cyc = 0;

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  dlp_lane_top #(.HALF_CYC(dlp_pkg::HALF_CYC)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .wr_start, .ca_par_err, .dq_i, .dq_o,
    .dq_oe_n, .dqs_t_i, .dqs_c_i, .dqs_t_o, .dqs_c_o, .dqs_oe_n, .dmi_i,
    .dmi_o, .dmi_oe_n, .on_die_termination_value, .dqs_rtt, .tdqs_rtt,
    .alert_n, .irq
  );
  dlp_host_model host (
    .aclk, .dqs_t(dqs_t_i), .dqs_c(dqs_c_i), .dq(dq_i), .dmi(dmi_i)
  );

  task automatic close_out();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  // Expected captured beat: inversion, mask, lane width
  function automatic logic [15:0] expw(logic [15:0] d, logic [1:0] m,
      logic [15:0] o, logic [1:0] md, logic dbi);
    logic [15:0] r;
    r = d;
    for (int b = 0; b < 2; b++) begin
      if ((b == 0 ? md != dlp_pkg::MODE_X4 : md == dlp_pkg::MODE_X16)
          && !m[b]) r[8*b +: 8] = dbi ? ~d[8*b +: 8] : o[8*b +: 8];
    end
    return r & (md == dlp_pkg::MODE_X4 ? 16'h000F :
      md == dlp_pkg::MODE_X8 ? 16'h00FF : 16'hFFFF);
  endfunction

  task automatic fill(input logic [1:0] md, input logic dbi, input logic rm);
    crc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      host.beat[i] = 16'($urandom);
      host.mask[i] = rm ? 2'($urandom) : 2'h3;
      wexp[i] = expw(host.beat[i], host.mask[i], wexp[i], md, dbi);
      crc ^= wexp[i][7:0] ^ wexp[i][15:8];
    end
  endtask

  task automatic wburst(input int n);
    wr_start <= 1'h1;
    @(posedge aclk);
    wr_start <= 1'h0;
    host.send(n);
    v = 32'h0000_0000;
    repeat (20) if (!v[dlp_pkg::ST_WDONE]) axr(dlp_pkg::OFF_STAT, v);
    `CHK(v[dlp_pkg::ST_WDONE], 1'h1)
  endtask

  task automatic cmpw();
    for (int i = 0; i < 8; i++) begin
      axr(8'(dlp_pkg::OFF_WBUF + 4 * i), v);
      `CHK(v, {16'h0000, wexp[i]})
    end
  endtask

  task automatic rd_check(input logic [15:0] d, input logic odd);
    logic [15:0] e;
    logic [1:0] m;
    e = d;
    m = 2'h3;
    for (int b = 0; b < 2; b++) begin
      if ($countones(d[8*b +: 8]) < 4) begin
        e[8*b +: 8] = ~d[8*b +: 8];
        m[b] = 1'h0;
      end
    end
    `CHK(dq_o, e)
    `CHK(dmi_o, m)
    `CHK({dqs_t_o, dqs_c_o, dqs_oe_n, dmi_oe_n, dq_oe_n},
      {!odd, odd, 4'h0, 16'h0000})
  endtask

  initial begin
    void'($urandom(66047));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    `CHK({alert_n, dq_oe_n, dqs_oe_n}, {1'h1, 16'hFFFF, 2'h3})
    axr(dlp_pkg::OFF_CTRL, v);
    `CHK(v, 32'h0000_0002)
    axr(8'hFC, v);
    `CHK(rsp, dlp_pkg::RESP_SLVERR)
    axw(8'hFC, 32'h0000_0001);
    `CHK(rsp, dlp_pkg::RESP_SLVERR)
    // Mask mode in every width, unmasked then random mask
    for (int md = 0; md < 3; md++) begin
      for (int p = 0; p < 2; p++) begin
        axw(dlp_pkg::OFF_CTRL, 32'(md));
        fill(2'(md), 1'h0, p[0]);
        wburst(8);
        cmpw();
        axw(dlp_pkg::OFF_STAT, 32'h0000_000F);
      end
    end
    // Write inversion with CRC: good, bad, bad with check off
    for (int j = 0; j < 3; j++) begin
      axw(dlp_pkg::OFF_CTRL, j == 0 ? 32'h0000_00A5 :
        j == 1 ? 32'h0000_00A6 : 32'h0000_0026);
      fill(j == 0 ? dlp_pkg::MODE_X8 : dlp_pkg::MODE_X16, 1'h1, 1'h1);
      host.beat[8] = {8'h00, crc ^ 8'(j != 0)};
      host.mask[8] = 2'h3;
      wburst(9);
      cmpw();
      repeat (4) @(posedge aclk);
      `CHK(alert_n, j != 1)
      axr(dlp_pkg::OFF_STAT, v);
      if (j < 2) `CHK(v[dlp_pkg::ST_CRC], j == 1)
      axw(dlp_pkg::OFF_STAT, 32'h0000_000F);
      repeat (2) @(posedge aclk);
      `CHK(alert_n, 1'h1)
    end
    // Parity error with check off, then on
    for (int j = 0; j < 2; j++) begin
      axw(dlp_pkg::OFF_CTRL, j ? 32'h0000_0042 : 32'h0000_0002);
      ca_par_err <= 1'h1;
      @(posedge aclk);
      ca_par_err <= 1'h0;
      repeat (4) @(posedge aclk);
      `CHK(alert_n, !j[0])
      axw(dlp_pkg::OFF_STAT, 32'h0000_000F);
      repeat (2) @(posedge aclk);
      `CHK(alert_n, 1'h1)
    end
    // Read burst in x16 with read inversion
    axw(dlp_pkg::OFF_CTRL, 32'h0000_0012);
    axw(dlp_pkg::OFF_MASK, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      rexp[i] = 16'($urandom);
      axw(8'(dlp_pkg::OFF_RBUF + 4 * i), {16'h0000, rexp[i]});
    end
    axw(dlp_pkg::OFF_RGO, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      rd_check(rexp[k], k[0]);
      repeat (dlp_pkg::HALF_CYC) @(posedge aclk);
    end
    `CHK({dqs_oe_n, dqs_t_o, dqs_c_o}, 4'hD)
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'h0)
    axw(dlp_pkg::OFF_MASK, 32'h0000_0008);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h1)
    axw(dlp_pkg::OFF_STAT, 32'h0000_0008);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'h0)
    // Reference monitor and termination strobe
    axw(dlp_pkg::OFF_RTT, 32'h0000_0003);
    axw(dlp_pkg::OFF_VREF, 32'h0000_0005);
    axw(dlp_pkg::OFF_CTRL, 32'h0000_000A);
    repeat (2) @(posedge aclk);
    `CHK({dq_o[3:0], dq_oe_n[3:0], on_die_termination_value, dqs_rtt},
      {4'h5, 4'h0, 3'h0, 3'h3})
    axw(dlp_pkg::OFF_CTRL, 32'h0000_0101);
    repeat (2) @(posedge aclk);
    `CHK(tdqs_rtt, 3'h3)
    axw(dlp_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    `CHK(tdqs_rtt, 3'h0)
    close_out();
  end
endmodule
`default_nettype wire
